// ---- line_thermal_defs.vh ----
`ifndef LINE_THERMAL_DEFS_VH
`define LINE_THERMAL_DEFS_VH

// Operating modes
`define MODE_OFF             2'h0
`define MODE_PULSED          2'h1
`define MODE_LOCKED          2'h2

// Temperature settings in degrees: minimum, maximum, default
`define ALARM_MIN            8'h3C
`define ALARM_MAX            8'hC8
`define ALARM_DEF            8'h50
`define TRIP_MIN             8'h3C
`define TRIP_MAX             8'hC8
`define TRIP_DEF             8'h64
`define RATED_MIN            8'h3C
`define RATED_MAX            8'hC8
`define RATED_DEF            8'h64
`define BASE_MIN             8'h00
`define BASE_MAX             8'h28
`define BASE_DEF             8'h19
`define UNLOCK_MIN           8'h14
`define UNLOCK_MAX           8'hC8
`define UNLOCK_DEF           8'h3C
`define AMBIENT_MIN          8'h00
`define AMBIENT_MAX          8'h28
`define AMBIENT_DEF          8'h19

// Percentage settings
`define STARTUP_MIN          8'h00
`define STARTUP_MAX          8'h3C
`define STARTUP_DEF          8'h00
`define LOAD_MIN             8'h14
`define LOAD_MAX             8'h96
`define LOAD_DEF             8'h64
`define PCT_FULL             48'h0000_0000_0064

// Time constant in minutes
`define TAU_MIN              10'h001
`define TAU_MAX              10'h3E7
`define TAU_DEF              10'h00A

// Timing
`define STEP_PERIOD_MS       1
`define MS_PER_MIN           60000
`define STEPS_PER_MIN        (`MS_PER_MIN / `STEP_PERIOD_MS)

// RMS window: one 50 Hz period of 1 kHz samples
`define RMS_WIN              20
`define RMS_WIN_M1           5'h13
`define RMS_SUM_DIV          37'h00_0000_0014

// Thermal level fixed point: 1.0 is 2**32
`define HEAT_FRAC            32
`define HEAT_MAX             48'hFFFF_FFFF_FFFF

`endif

// ---- line_thermal_function.v ----
// Overview of operation
// - True RMS per phase from 1 kHz samples over one sliding window.
// - Largest of the three phase RMS values is the heating current.
// - Heat = old*(1-dt/T) + dt/T * current squared over rated squared.
// - Object temperature is overtemperature plus ambient temperature.
// - Measured ambient input used only when sensor select chooses it.
// - Sensor select defaults to No, choosing the ambient setting.
// - Temperature compared each step with alarm, trip and unlock settings.
// - Off mode keeps trip, alarm and reclose lock outputs inactive.
// - Pulsed mode emits a trip pulse when temperature rises above trip.
// - Locked mode holds trip from above trip until below unlock.
// - Alarm setting 60 to 200 degrees, default 80.
// - Trip setting 60 to 200 degrees, default 100.
// - Rated temperature setting 60 to 200 degrees, default 100.
// - Base temperature setting 0 to 40 degrees, default 25.
// - Unlock setting 20 to 200 degrees, default 60.
// - Ambient setting 0 to 40 degrees, default 25.
// - Startup setting 0 to 60 percent, default 0.
// - At start, heat loads startup percent of rated rise.
// - Rated load current 20 to 150 percent, default 100, reference current.
// - Time constant 1 to 999 minutes, default 10.
// - Heat reset reloads starting value; block input disables the function.
`timescale 1ns/1ps
`default_nettype none
`include "line_thermal_defs.vh"

module line_thermal_function
(
   // Clock, reset, enable
   input  wire               clk_in,
   input  wire               rstn_in,
   input  wire               clk_en_in,
   // Samples
   input  wire               sample_valid_in,
   input  wire signed [15:0] phase_a_current_in,
   input  wire signed [15:0] phase_b_current_in,
   input  wire signed [15:0] phase_c_current_in,
   input  wire        [7:0]  ambient_meas_in,
   // Settings
   input  wire               settings_write_in,
   input  wire        [1:0]  operating_mode_setting_in,
   input  wire        [7:0]  alarm_temp_setting_in,
   input  wire        [7:0]  trip_temp_setting_in,
   input  wire        [7:0]  rated_temp_setting_in,
   input  wire        [7:0]  base_temp_setting_in,
   input  wire        [7:0]  unlock_temp_setting_in,
   input  wire        [7:0]  ambient_temp_setting_in,
   input  wire        [7:0]  startup_temp_setting_in,
   input  wire        [7:0]  rated_load_current_setting_in,
   input  wire        [9:0]  time_constant_setting_in,
   input  wire               ambient_sensor_select_in,
   // Control
   input  wire               heat_reset_input_in,
   input  wire               function_block_input_in,
   // Status
   output reg                alarm_out,
   output reg                trip_out,
   output reg                reclose_lock_out,
   output reg         [15:0] temperature_out,
   output reg         [15:0] phase_a_rms_out,
   output reg         [15:0] phase_b_rms_out,
   output reg         [15:0] phase_c_rms_out
);

   //==========================================================
   // Functions
   function [7:0] clamp8;
      input [7:0] v;
      input [7:0] lo;
      input [7:0] hi;
      begin
         clamp8 = (v < lo) ? lo : ((v > hi) ? hi : v);
      end
   endfunction

   function [31:0] square16;
      input signed [15:0] v;
      reg [15:0] m;
      begin
         m = v[15] ? (16'h0000 - v) : v;
         square16 = m * m;
      end
   endfunction

   function [15:0] isqrt;
      input [31:0] v;
      reg [15:0] r;
      reg [15:0] c;
      integer    i;
      begin
         r = 16'h0000;
         for (i = 15; i >= 0; i = i - 1)
         begin
            c = r | (16'h0001 << i);
            if (c * c <= v)
               r = c;
         end
         isqrt = r;
      end
   endfunction

   //==========================================================
   // Settings
   reg [1:0] mode_q;
   reg [7:0] alarm_q;
   reg [7:0] trip_q;
   reg [7:0] rated_q;
   reg [7:0] base_q;
   reg [7:0] unlock_q;
   reg [7:0] ambient_q;
   reg [7:0] startup_q;
   reg [7:0] load_q;
   reg [9:0] tau_q;
   reg       sensor_sel_q;

   always @(posedge clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         mode_q       <= `MODE_PULSED;
         alarm_q      <= `ALARM_DEF;
         trip_q       <= `TRIP_DEF;
         rated_q      <= `RATED_DEF;
         base_q       <= `BASE_DEF;
         unlock_q     <= `UNLOCK_DEF;
         ambient_q    <= `AMBIENT_DEF;
         startup_q    <= `STARTUP_DEF;
         load_q       <= `LOAD_DEF;
         tau_q        <= `TAU_DEF;
         sensor_sel_q <= 1'b0;
      end
      else if (clk_en_in && settings_write_in)
      begin
         mode_q    <= (operating_mode_setting_in > `MODE_LOCKED) ?
                      mode_q : operating_mode_setting_in;
         alarm_q   <= clamp8(alarm_temp_setting_in, `ALARM_MIN,
                             `ALARM_MAX);
         trip_q    <= clamp8(trip_temp_setting_in, `TRIP_MIN,
                             `TRIP_MAX);
         rated_q   <= clamp8(rated_temp_setting_in, `RATED_MIN,
                             `RATED_MAX);
         base_q    <= clamp8(base_temp_setting_in, `BASE_MIN,
                             `BASE_MAX);
         unlock_q  <= clamp8(unlock_temp_setting_in, `UNLOCK_MIN,
                             `UNLOCK_MAX);
         ambient_q <= clamp8(ambient_temp_setting_in, `AMBIENT_MIN,
                             `AMBIENT_MAX);
         startup_q <= clamp8(startup_temp_setting_in, `STARTUP_MIN,
                             `STARTUP_MAX);
         load_q    <= clamp8(rated_load_current_setting_in, `LOAD_MIN,
                             `LOAD_MAX);
         tau_q     <= (time_constant_setting_in < `TAU_MIN) ? `TAU_MIN :
                      ((time_constant_setting_in > `TAU_MAX) ? `TAU_MAX :
                      time_constant_setting_in);
         sensor_sel_q <= ambient_sensor_select_in;
      end
   end

   //==========================================================
   // Sliding sum of squares per phase
   reg  [31:0] sq_mem [0:3*`RMS_WIN-1];
   reg  [36:0] sum_q  [0:2];
   reg  [4:0]  ptr_q;
   reg  [4:0]  fill_q;
   reg         s1_q;
   wire [31:0] new_sq [0:2];
   integer     p;
   integer     k;

   assign new_sq[0] = square16(phase_a_current_in);
   assign new_sq[1] = square16(phase_b_current_in);
   assign new_sq[2] = square16(phase_c_current_in);

   always @(posedge clk_in)
   begin
      if (clk_en_in && sample_valid_in)
      begin
         for (p = 0; p < 3; p = p + 1)
            sq_mem[p*`RMS_WIN+ptr_q] <= new_sq[p];
      end
   end

   always @(posedge clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         for (k = 0; k < 3; k = k + 1)
            sum_q[k] <= 37'h00_0000_0000;
         ptr_q  <= 5'h00;
         fill_q <= 5'h00;
         s1_q   <= 1'b0;
      end
      else if (clk_en_in)
      begin
         s1_q <= sample_valid_in;
         if (sample_valid_in)
         begin
            for (k = 0; k < 3; k = k + 1)
               sum_q[k] <= sum_q[k] + {5'h00, new_sq[k]} -
                  ((fill_q == `RMS_WIN) ?
                   {5'h00, sq_mem[k*`RMS_WIN+ptr_q]} :
                   37'h00_0000_0000);
            ptr_q <= (ptr_q == `RMS_WIN_M1) ? 5'h00 : ptr_q + 5'h01;
            if (fill_q != `RMS_WIN)
               fill_q <= fill_q + 5'h01;
         end
      end
   end

   //==========================================================
   // RMS per phase from the mean of squares
   reg  [36:0] mean_a;
   reg  [36:0] mean_b;
   reg  [36:0] mean_c;
   reg         s2_q;

   always @*
   begin
      mean_a = sum_q[0] / `RMS_SUM_DIV;
      mean_b = sum_q[1] / `RMS_SUM_DIV;
      mean_c = sum_q[2] / `RMS_SUM_DIV;
   end

   always @(posedge clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         phase_a_rms_out <= 16'h0000;
         phase_b_rms_out <= 16'h0000;
         phase_c_rms_out <= 16'h0000;
         s2_q            <= 1'b0;
      end
      else if (clk_en_in)
      begin
         s2_q <= s1_q;
         if (s1_q)
         begin
            phase_a_rms_out <= isqrt(mean_a[31:0]);
            phase_b_rms_out <= isqrt(mean_b[31:0]);
            phase_c_rms_out <= isqrt(mean_c[31:0]);
         end
      end
   end

   //==========================================================
   // Thermal replica
   reg  [15:0]        max_rms;
   reg  [31:0]        max_sq;
   reg  [63:0]        ratio;
   reg  [47:0]        ratio_c;
   reg  [31:0]        tau_steps;
   reg  signed [64:0] diff;
   reg  signed [64:0] delta;
   reg  [47:0]        start_heat;
   reg  [47:0]        heat_q;
   reg                init_q;
   reg                s3_q;

   always @*
   begin
      max_rms = phase_a_rms_out;
      if (phase_b_rms_out > max_rms)
         max_rms = phase_b_rms_out;
      if (phase_c_rms_out > max_rms)
         max_rms = phase_c_rms_out;
      max_sq    = max_rms * max_rms;
      ratio     = {max_sq, 32'h0000_0000} /
                  {48'h0000_0000_0000,
                   {8'h00, load_q} * {8'h00, load_q}};
      ratio_c   = (ratio > {16'h0000, `HEAT_MAX}) ? `HEAT_MAX :
                  ratio[47:0];
      tau_steps = tau_q * `STEPS_PER_MIN;
      diff      = $signed({17'h0_0000, ratio_c}) -
                  $signed({17'h0_0000, heat_q});
      delta     = diff / $signed({33'h0_0000_0000, tau_steps});
      start_heat = {8'h00, startup_q, 32'h0000_0000} / `PCT_FULL;
   end

   always @(posedge clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         heat_q <= 48'h0000_0000_0000;
         init_q <= 1'b1;
         s3_q   <= 1'b0;
      end
      else if (clk_en_in)
      begin
         s3_q <= s2_q && !function_block_input_in;
         if (init_q || heat_reset_input_in)
         begin
            heat_q <= start_heat;
            init_q <= 1'b0;
         end
         else if (s2_q && !function_block_input_in)
            heat_q <= heat_q + delta[47:0];
      end
   end

   //==========================================================
   // Temperature and decisions
   reg  [55:0] rise_full;
   reg  [7:0]  ambient_now;
   reg  [24:0] temp;
   reg         above_trip;
   reg         above_trip_q;
   reg         lock_q;
   reg         lock_d;
   reg         active;

   always @*
   begin
      rise_full   = heat_q * {40'h00_0000_0000, rated_q - base_q};
      ambient_now = sensor_sel_q ? ambient_meas_in : ambient_q;
      temp        = {1'b0, rise_full[55:`HEAT_FRAC]} +
                    {17'h0_0000, ambient_now};
      above_trip  = temp > {17'h0_0000, trip_q};
      lock_d      = lock_q;
      if (above_trip)
         lock_d = 1'b1;
      else if (temp < {17'h0_0000, unlock_q})
         lock_d = 1'b0;
      active      = (mode_q != `MODE_OFF) && !function_block_input_in;
   end

   always @(posedge clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         alarm_out        <= 1'b0;
         trip_out         <= 1'b0;
         reclose_lock_out <= 1'b0;
         temperature_out  <= 16'h0000;
         above_trip_q     <= 1'b0;
         lock_q           <= 1'b0;
      end
      else if (clk_en_in)
      begin
         if (!active)
         begin
            alarm_out        <= 1'b0;
            trip_out         <= 1'b0;
            reclose_lock_out <= 1'b0;
            lock_q           <= 1'b0;
            above_trip_q     <= 1'b0;
         end
         else if (s3_q)
         begin
            temperature_out <= (temp[24:16] != 9'h000) ? 16'hFFFF :
                               temp[15:0];
            alarm_out    <= temp > {17'h0_0000, alarm_q};
            above_trip_q <= above_trip;
            lock_q       <= lock_d;
            reclose_lock_out <= lock_d;
            case (mode_q)
               `MODE_PULSED:
                  trip_out <= above_trip && !above_trip_q;
               `MODE_LOCKED:
                  trip_out <= lock_d;
               default:
                  trip_out <= 1'b0;
            endcase
         end
      end
   end

endmodule

`default_nettype wire

// ---- thermal_checker_properties.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "line_thermal_defs.vh"
module thermal_checker
(
   // Clock and reset
   input wire logic        clk_in,
   input wire logic        rstn_in,
   input wire logic        clk_en_in,
   // Inputs
   input wire logic        sample_valid_in,
   input wire logic        settings_write_in,
   input wire logic [1:0]  operating_mode_setting_in,
   input wire logic [7:0]  alarm_temp_setting_in,
   input wire logic [7:0]  trip_temp_setting_in,
   input wire logic [7:0]  unlock_temp_setting_in,
   input wire logic        function_block_input_in,
   // Outputs
   input wire logic        alarm_out,
   input wire logic        trip_out,
   input wire logic        reclose_lock_out,
   input wire logic [15:0] temperature_out,
   input wire logic [15:0] phase_a_rms_out
);
   // ==========
   // Settings as held
   logic [1:0] mode_q;
   logic [7:0] alarm_q;
   logic [7:0] trip_q;
   logic [7:0] unl_q;
   logic [1:0] vh_q;
   logic       quiet;
   function automatic logic [7:0] clp(input logic [7:0] v, lo, hi);
      return (v < lo) ? lo : ((v > hi) ? hi : v);
   endfunction
   assign quiet = !(alarm_out | trip_out | reclose_lock_out);
   always_ff @(posedge clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         mode_q  <= `MODE_PULSED;
         alarm_q <= `ALARM_DEF;
         trip_q  <= `TRIP_DEF;
         unl_q   <= `UNLOCK_DEF;
         vh_q    <= 2'h0;
      end
      else if (clk_en_in)
      begin
         vh_q <= {vh_q[0], sample_valid_in};
         if (settings_write_in)
         begin
            if (operating_mode_setting_in != 2'h3)
               mode_q <= operating_mode_setting_in;
            alarm_q <= clp(alarm_temp_setting_in, `ALARM_MIN, `ALARM_MAX);
            trip_q  <= clp(trip_temp_setting_in, `TRIP_MIN, `TRIP_MAX);
            unl_q   <= clp(unlock_temp_setting_in, `UNLOCK_MIN, `UNLOCK_MAX);
         end
      end
   end
   // ==========
   // Properties
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!rstn_in);
   a_block_quiet:
      assert property (function_block_input_in [*2] |-> quiet)
      else $error("output active while blocked");
   a_off_quiet:
      assert property ((mode_q == `MODE_OFF) [*3] |-> quiet)
      else $error("output active in off mode");
   a_pulse_width:
      assert property (mode_q == `MODE_PULSED && trip_out
         && sample_valid_in && clk_en_in
         |-> ##[2:5] !trip_out)
      else $error("trip pulse longer than one step");
   a_alarm_above:
      assert property ($rose(alarm_out) |-> temperature_out > alarm_q)
      else $error("alarm below setting");
   a_trip_above:
      assert property (mode_q == `MODE_PULSED && $rose(trip_out)
         |-> temperature_out > trip_q)
      else $error("trip below setting");
   a_lock_release:
      assert property ($fell(reclose_lock_out) |-> temperature_out < unl_q
         || mode_q == `MODE_OFF || $past(function_block_input_in))
      else $error("lock released above unlock");
   a_locked_hold:
      assert property (mode_q == `MODE_LOCKED && trip_out
         && !function_block_input_in && !settings_write_in
         |=> trip_out || temperature_out < unl_q)
      else $error("locked trip dropped early");
   a_rms_step:
      assert property ($changed(phase_a_rms_out) |-> |vh_q)
      else $error("rms changed without sample");
endmodule
bind line_thermal_function thermal_checker chk_u
(
   .clk_in(clk_in), .rstn_in(rstn_in), .clk_en_in(clk_en_in),
   .sample_valid_in(sample_valid_in),
   .settings_write_in(settings_write_in),
   .operating_mode_setting_in(operating_mode_setting_in),
   .alarm_temp_setting_in(alarm_temp_setting_in),
   .trip_temp_setting_in(trip_temp_setting_in),
   .unlock_temp_setting_in(unlock_temp_setting_in),
   .function_block_input_in(function_block_input_in),
   .alarm_out(alarm_out), .trip_out(trip_out),
   .reclose_lock_out(reclose_lock_out), .temperature_out(temperature_out),
   .phase_a_rms_out(phase_a_rms_out)
);
`default_nettype wire

// ---- sample_front_end.sv ----
`timescale 1ns/1ps
`default_nettype none
module sample_front_end
#(
   parameter int GAP = 8
)
(
   // Clock
   input  wire logic               clk_in,
   // Samples
   output var  logic               valid_out,
   output var  logic signed [15:0] a_out,
   output var  logic signed [15:0] b_out,
   output var  logic signed [15:0] c_out
);
   // ==========
   // Sample delivery
   initial
   begin
      valid_out = 1'b0;
      a_out = 16'sh0000;
      b_out = 16'sh0000;
      c_out = 16'sh0000;
   end
   task automatic send(input logic signed [15:0] a, b, c);
      @(negedge clk_in);
      valid_out = 1'b1;
      a_out = a;
      b_out = b;
      c_out = c;
      @(negedge clk_in);
      valid_out = 1'b0;
      // Stale data is not held
      a_out = ~a;
      b_out = ~b;
      c_out = ~c;
      repeat (GAP) @(negedge clk_in);
   endtask
endmodule
`default_nettype wire

// ---- testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "line_thermal_defs.vh"
module testbench;
   // ==========
   // Signals
   logic               clk_in, rstn_in, wr, sens, hrst, blk, valid, en;
   logic               alarm, trip, lock;
   logic [1:0]         mode;
   logic [7:0]         amb_m, al, tr, ra, ba, un, am, st, ld;
   logic [9:0]         tau;
   logic signed [15:0] ia, ib, ic;
   logic [15:0]        temp, rms_a, rms_b, rms_c;
   int                 n_errors, comparisons;
   sample_front_end #(.GAP(8)) src_u
   (
      .clk_in(clk_in), .valid_out(valid), .a_out(ia), .b_out(ib), .c_out(ic)
   );
   line_thermal_function dut_u
   (
      .clk_in(clk_in), .rstn_in(rstn_in), .clk_en_in(en),
      .sample_valid_in(valid), .phase_a_current_in(ia),
      .phase_b_current_in(ib), .phase_c_current_in(ic),
      .ambient_meas_in(amb_m), .settings_write_in(wr),
      .operating_mode_setting_in(mode), .alarm_temp_setting_in(al),
      .trip_temp_setting_in(tr), .rated_temp_setting_in(ra),
      .base_temp_setting_in(ba), .unlock_temp_setting_in(un),
      .ambient_temp_setting_in(am), .startup_temp_setting_in(st),
      .rated_load_current_setting_in(ld), .time_constant_setting_in(tau),
      .ambient_sensor_select_in(sens), .heat_reset_input_in(hrst),
      .function_block_input_in(blk), .alarm_out(alarm), .trip_out(trip),
      .reclose_lock_out(lock), .temperature_out(temp),
      .phase_a_rms_out(rms_a), .phase_b_rms_out(rms_b),
      .phase_c_rms_out(rms_c)
   );
   // ==========
   // Tasks
   task automatic chk(input string nm, input logic [15:0] e, g);
      comparisons++;
      if (g !== e)
      begin
         n_errors++;
         $display("unexpected %s: expected %0h seen %0h", nm, e, g);
      end
   endtask
   task automatic rng(input string nm, input logic [15:0] lo, hi, g);
      chk(nm, 16'h0001, {15'h0000, (g >= lo && g <= hi)});
   endtask
   task automatic step(input int n, input logic signed [15:0] a, b, c);
      repeat (n) src_u.send(a, b, c);
   endtask
   task automatic sf(input logic [2:0] e);
      step(1, 0, 0, 0);
      chk("flags", {13'h0000, e}, {13'h0000, alarm, trip, lock});
   endtask
   task automatic wr_set;
      @(negedge clk_in);
      wr = 1'b1;
      @(negedge clk_in);
      wr = 1'b0;
   endtask
   task automatic heat0;
      @(negedge clk_in);
      hrst = 1'b1;
      repeat (2) @(negedge clk_in);
      hrst = 1'b0;
   endtask
   task automatic conclude;
      $display("comparisons %0d n_errors %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // ==========
   // Clock and watchdog
   initial
   begin
      clk_in = 1'b0;
      forever #4 clk_in = ~clk_in;
   end
   initial
   begin
      repeat (20000) @(posedge clk_in);
      n_errors++;
      $display("unexpected run: expected done seen hang");
      conclude();
   end
   // ==========
   // Tests
   initial
   begin
      {rstn_in, wr, sens, hrst, blk} = 5'h00;
      en = 1'b1;
      amb_m = 8'h00;
      mode = `MODE_PULSED;
      {al, tr, ra, ba} = {`ALARM_DEF, `TRIP_DEF, `RATED_DEF, `BASE_DEF};
      {un, am, st, ld} = {`UNLOCK_DEF, `AMBIENT_DEF, `STARTUP_DEF, `LOAD_DEF};
      tau = `TAU_DEF;
      n_errors = 0;
      comparisons = 0;
      repeat (8) @(negedge clk_in);
      rstn_in = 1'b1;
      step(1, 0, 0, 0);
      chk("temp", 16'h0019, temp);
      sens = 1'b1;
      amb_m = 8'h21;
      wr_set();
      step(1, 0, 0, 0);
      chk("temp", 16'h0021, temp);
      step(20, 16'sh0064, -16'sh00C8, 16'sh0032);
      chk("rms_a", 16'h0064, rms_a);
      chk("rms_b", 16'h00C8, rms_b);
      chk("rms_c", 16'h0032, rms_c);
      en = 1'b0;
      step(1, 16'sh1000, 16'sh1000, 16'sh1000);
      en = 1'b1;
      chk("rms_a", 16'h0064, rms_a);
      step(20, 0, 0, 0);
      sens = 1'b0;
      {ra, ba, st, al, tr} = {8'hC8, 8'h00, 8'h3C, 8'h8C, 8'h8E};
      wr_set();
      heat0();
      sf(3'b111);
      rng("temp", 16'h0090, 16'h0091, temp);
      sf(3'b101);
      mode = `MODE_LOCKED;
      al = 8'hFA;
      wr_set();
      sf(3'b011);
      {tr, un} = {8'h96, 8'h64};
      wr_set();
      sf(3'b011);
      un = 8'h96;
      wr_set();
      sf(3'b000);
      {tr, un} = {8'h3C, 8'h14};
      wr_set();
      sf(3'b011);
      mode = 2'h3;
      wr_set();
      sf(3'b011);
      mode = `MODE_OFF;
      wr_set();
      sf(3'b000);
      mode = `MODE_PULSED;
      blk = 1'b1;
      wr_set();
      sf(3'b000);
      blk = 1'b0;
      {al, tr, un, st, ld} = {8'h64, 8'h78, 8'h3C, 8'h00, 8'h14};
      tau = 10'h001;
      wr_set();
      heat0();
      step(1, 0, 0, 16'sh3E80);
      rng("temp", 16'h0081, 16'h0085, temp);
      conclude();
   end
endmodule
`default_nettype wire
